// file: include/rpgoc_cfg.svh
// Offsets, field positions, masks and reset values of the pixel gain/offset/clip stage.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef RPGOC_CFG_SVH
`define RPGOC_CFG_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define RPGOC_ADDR_GAIN    8'h00
`define RPGOC_ADDR_OFFSET  8'h04
`define RPGOC_ADDR_CLIP    8'h08
`define RPGOC_ADDR_LINEA   8'h0c
`define RPGOC_ADDR_LINEB   8'h10
`define RPGOC_ADDR_SETUP   8'h14
`define RPGOC_ADDR_BT656   8'h18
`define RPGOC_ADDR_MEDTHR  8'h1c
`define RPGOC_ADDR_STATUS  8'h20
`define RPGOC_ADDR_MASK    8'h24

// ----------------------------------------------------------------
// Field layouts
// ----------------------------------------------------------------
`define RPGOC_SETUP_MASK   16'h0f3d
`define RPGOC_SETUP_PIPE   11:10
`define RPGOC_SETUP_CAP    9:8
`define RPGOC_SETUP_STRIPE 5
`define RPGOC_SETUP_SLICE  4:2
`define RPGOC_SETUP_ALAW   0
`define RPGOC_BT656_ON     0
`define RPGOC_BT656_ECC    1
`define RPGOC_STAT_LINE    30:16
`define RPGOC_GAIN_FRAC    8
`define RPGOC_SLICE_MAX    3'h4
`define RPGOC_ALAW_MANT    5
`define RPGOC_LINE_MAX     15'h7fff

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RPGOC_GAIN_UNITY   11'h100
`define RPGOC_GAIN_RST     11'h100
`define RPGOC_CLIP_RST     14'h3fff

`endif

// file: include/rpgoc_pkg.sv
// Types shared by the pixel gain/offset/clip stage.
// Assumes nothing of its surroundings.
package rpgoc_pkg;
	typedef logic [13:0] rpgoc_pix_t;
	typedef enum logic [1:0] {RPGOC_FILT_NONE, RPGOC_FILT_AVG, RPGOC_FILT_MEDIAN, RPGOC_FILT_RSVD} rpgoc_fmode_t;
endpackage

// file: hw/rpgoc_gain_clip.sv
// Gain, offset and ceiling clip of one raw sample, one register stage.
// Assumes gain and offset already latched per frame by the caller.
`timescale 1ns/10ps
`default_nettype none
`include "rpgoc_cfg.svh"

module rpgoc_gain_clip
	import rpgoc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire rpgoc_pix_t  inPix,
	input  wire logic        inValid,
	input  wire logic        inBlue,
	input  wire logic [10:0] gain,
	input  wire logic [9:0]  offset,
	input  wire rpgoc_pix_t  clip,
	output rpgoc_pix_t       outPix,
	output logic             outValid
);
	logic [10:0] gainUse;
	logic [24:0] product;
	logic [16:0] scaled;
	logic [17:0] sum;
	rpgoc_pix_t  clipped;
	rpgoc_pix_t  pixQ;
	logic        validQ;

	// Unity gain for samples that are not blue/magenta
	assign gainUse = inBlue ? gain : `RPGOC_GAIN_UNITY; // see R1
	assign product = inPix * gainUse;                   // see R1
	assign scaled  = product[24:`RPGOC_GAIN_FRAC];      // see R1
	assign sum     = {1'b0, scaled} + {8'h00, offset};  // see R2
	// Wide compare so a gain overflow still clips
	assign clipped = (sum > {4'h0, clip}) ? clip : sum[13:0]; // see R3

	// Output stage
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pixQ   <= '0;
			validQ <= 1'b0;
		end else begin
			if (inValid) begin
				pixQ <= clipped;
			end
			validQ <= inValid;
		end
	end

	assign outPix   = pixQ;
	assign outValid = validQ;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	chk_clip_ceiling: assert property (outValid |-> outPix <= $past(clip)) // see R3
		else $error("sample above clip ceiling");
	chk_offset_only: assert property (inValid && gain == 11'h000 && inBlue && clip == 14'h3fff
		|=> outPix == 14'($past(offset))) // see R2
		else $error("offset not added after zero gain");
	chk_gain_unity: assert property (inValid && !inBlue && offset == 10'h000 && clip == 14'h3fff
		|=> outPix == $past(inPix)) // see R1
		else $error("non blue sample changed by gain");
endmodule
`default_nettype wire

// file: hw/rpgoc_filter3.sv
// Three-sample horizontal filter: none, average or thresholded median.
// Assumes a stream of valid samples; output is the window centre, two samples late.
`timescale 1ns/10ps
`default_nettype none
`include "rpgoc_cfg.svh"

module rpgoc_filter3
	import rpgoc_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          nrst,
	input  wire rpgoc_pix_t    inPix,
	input  wire logic          inValid,
	input  wire rpgoc_fmode_t  mode,
	input  wire rpgoc_pix_t    threshold,
	output rpgoc_pix_t         outPix,
	output logic               outValid
);
	rpgoc_pix_t  winQ [3];
	rpgoc_pix_t  loAB, hiAB, med, diff, filt;
	logic [15:0] avgSum;
	rpgoc_pix_t  pixQ;
	logic        validQ;

	// Window shift, one entry per stage
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			winQ[0] <= '0;
		end else if (inValid) begin
			winQ[0] <= inPix;
		end
	end
	for (genvar i = 1; i < 3; i++) begin : gWin
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				winQ[i] <= '0;
			end else if (inValid) begin
				winQ[i] <= winQ[i-1];
			end
		end
	end

	// Median of three; replaces centre only when it stands out past threshold
	assign loAB   = (winQ[0] < winQ[1]) ? winQ[0] : winQ[1];
	assign hiAB   = (winQ[0] < winQ[1]) ? winQ[1] : winQ[0];
	assign med    = (hiAB < winQ[2]) ? hiAB : ((loAB > winQ[2]) ? loAB : winQ[2]);
	assign diff   = (winQ[1] > med) ? winQ[1] - med : med - winQ[1]; // see R9
	// Weighted 1-2-1 average avoids a divide by three
	assign avgSum = {2'b00, winQ[0]} + {1'b0, winQ[1], 1'b0} + {2'b00, winQ[2]};

	// Mode select; reserved code behaves as no filter
	always_comb begin
		case (mode)
			RPGOC_FILT_NONE:   filt = winQ[1];                       // see R7, R8
			RPGOC_FILT_AVG:    filt = avgSum[15:2];                  // see R7, R8
			RPGOC_FILT_MEDIAN: filt = (diff > threshold) ? med : winQ[1]; // see R9
			default:           filt = winQ[1];
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pixQ   <= '0;
			validQ <= 1'b0;
		end else begin
			if (inValid) begin
				pixQ <= filt;
			end
			validQ <= inValid;
		end
	end

	assign outPix   = pixQ;
	assign outValid = validQ;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	chk_filter_bypass: assert property (inValid && mode == RPGOC_FILT_NONE |=> outPix == $past(winQ[1])) // see R7
		else $error("bypass mode altered sample");
	chk_median_pick: assert property (inValid && mode == RPGOC_FILT_MEDIAN
		|=> outPix == $past(winQ[1]) || outPix == $past(med)) // see R9
		else $error("median output outside choices");
	chk_average_pick: assert property (inValid && mode == RPGOC_FILT_AVG |=> outPix == $past(avgSum[15:2])) // see R8
		else $error("average output wrong");
endmodule
`default_nettype wire

// file: hw/rpgoc_top.sv
// Pixel conditioning stage: APB registers, frame latching, gain/clip, filters,
// slice select, A-law for capture and two line-count frame interrupts.
// Assumes sensor pins asynchronous to clk and held stable around their valid strobe.
//
// Behaviour
// R1: Blue/magenta samples are multiplied by an 11-bit gain with eight fraction bits.
// R2: A 10-bit offset is added to every sample after gain.
// R3: Each sample is saturated at a programmable 14-bit ceiling.
// R4: Gain, offset, filter, pattern, slice and A-law settings change only at vertical sync; the median threshold goes to the filters unlatched.
// R5: First frame interrupt fires at a programmed 15-bit line count after vertical sync.
// R6: Second, independent frame interrupt fires at its own 15-bit line count.
// R7: Image pipe path mode picks none, average or median filter; code 3 reserved.
// R8: Capture path has its own mode picking none, average or median filter.
// R9: Median filter is governed by a programmable 14-bit threshold.
// R10: Slice select picks which ten bits feed A-law and statistics; codes 5-7 reserved.
// R11: With enable set, captured data passes the A-law table before memory.
// R12: Each frame interrupt pulses once per frame when the line count first matches.
// R13: Reserved bits read zero and writes to them change nothing.
`timescale 1ns/10ps
`default_nettype none
`include "rpgoc_cfg.svh"

module rpgoc_top
	import rpgoc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        vertSyncPulse,
	input  wire logic        lineStartPulse,
	input  wire logic        pixValid,
	input  wire logic        pixBlueMag,
	input  wire logic [13:0] pixData,
	output logic [13:0]      pipeData,
	output logic             pipeValid,
	output logic [13:0]      capData,
	output logic             capValid,
	output logic [9:0]       statsData,
	output logic             statsValid,
	output logic             irq,
	output logic             bt656PortEnable,
	output logic             syncCodeCorrectionEnable,
	output logic             colourPatternStripe
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Ten-bit slice; reserved codes fall back to the top slice
	function automatic logic [9:0] sliceOf(input rpgoc_pix_t p, input logic [2:0] sel);
		logic [2:0] s;
		s = (sel > `RPGOC_SLICE_MAX) ? 3'h0 : sel;
		return 10'(p >> (`RPGOC_SLICE_MAX - s));
	endfunction

	// Segmented A-law style compression, ten bits to eight
	function automatic logic [7:0] alawOf(input logic [9:0] x);
		logic [7:0] code;
		code = {3'h0, x[4:0]};
		for (int p = `RPGOC_ALAW_MANT; p < 10; p++) begin
			if (x[p]) begin
				code = {3'(p - `RPGOC_ALAW_MANT + 1), 5'(x >> (p - `RPGOC_ALAW_MANT))};
			end
		end
		return code;
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [17:0] pinMetaQ;
	logic [17:0] pinSyncQ;
	logic        vsyncDlyQ;
	logic        hsyncDlyQ;
	logic        vsyncRise;
	logic        hsyncRise;

	// Two stages for every pin; pixel bus relies on data settling around its strobe
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pinMetaQ <= '0;
			pinSyncQ <= '0;
		end else begin
			pinMetaQ <= {vertSyncPulse, lineStartPulse, pixValid, pixBlueMag, pixData};
			pinSyncQ <= pinMetaQ;
		end
	end

	// Edge detectors look only at the second stage
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			vsyncDlyQ <= 1'b0;
			hsyncDlyQ <= 1'b0;
		end else begin
			vsyncDlyQ <= pinSyncQ[17];
			hsyncDlyQ <= pinSyncQ[16];
		end
	end

	assign vsyncRise = pinSyncQ[17] & ~vsyncDlyQ;
	assign hsyncRise = pinSyncQ[16] & ~hsyncDlyQ;

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	logic        preadyQ;
	logic        pslverrQ;
	logic [31:0] prdataQ;
	logic        apbAccess;
	logic        wrEn;
	logic        hitGain, hitOff, hitClip, hitLineA, hitLineB;
	logic        hitSetup, hitBt, hitThr, hitStat, hitMask, addrHit;
	logic [31:0] rdMux;

	// One wait state: pready rises in the second access cycle
	assign apbAccess = psel & penable & ~preadyQ;
	assign wrEn      = psel & penable & preadyQ & pwrite;

	// Address decode
	assign hitGain  = paddr == `RPGOC_ADDR_GAIN;
	assign hitOff   = paddr == `RPGOC_ADDR_OFFSET;
	assign hitClip  = paddr == `RPGOC_ADDR_CLIP;
	assign hitLineA = paddr == `RPGOC_ADDR_LINEA;
	assign hitLineB = paddr == `RPGOC_ADDR_LINEB;
	assign hitSetup = paddr == `RPGOC_ADDR_SETUP;
	assign hitBt    = paddr == `RPGOC_ADDR_BT656;
	assign hitThr   = paddr == `RPGOC_ADDR_MEDTHR;
	assign hitStat  = paddr == `RPGOC_ADDR_STATUS;
	assign hitMask  = paddr == `RPGOC_ADDR_MASK;
	assign addrHit  = hitGain | hitOff | hitClip | hitLineA | hitLineB | hitSetup | hitBt | hitThr | hitStat | hitMask;

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	logic [10:0] gainQ;
	logic [9:0]  offQ;
	rpgoc_pix_t  clipQ;
	logic [14:0] lineValQ [2];
	logic [15:0] setupQ;
	logic [1:0]  btQ;
	rpgoc_pix_t  thrQ;
	logic [1:0]  statusQ;
	logic [1:0]  maskQ;
	logic [1:0]  statusD;
	logic [1:0]  evtVec;
	logic [14:0] lineCntQ;

	// Only defined field bits are stored, so reserved bits stay zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gainQ       <= `RPGOC_GAIN_RST;
			offQ        <= '0;
			clipQ       <= `RPGOC_CLIP_RST;
			lineValQ[0] <= '0;
			lineValQ[1] <= '0;
			setupQ      <= '0;
			btQ         <= '0;
			thrQ        <= '0;
			maskQ       <= '0;
		end else if (wrEn) begin
			if (hitGain)  gainQ       <= pwdata[10:0];                     // see R13
			if (hitOff)   offQ        <= pwdata[9:0];                      // see R13
			if (hitClip)  clipQ       <= pwdata[13:0];                     // see R13
			if (hitLineA) lineValQ[0] <= pwdata[14:0];                     // see R5
			if (hitLineB) lineValQ[1] <= pwdata[14:0];                     // see R6
			if (hitSetup) setupQ      <= pwdata[15:0] & `RPGOC_SETUP_MASK; // see R13
			if (hitBt)    btQ         <= pwdata[1:0];
			if (hitThr)   thrQ        <= pwdata[13:0];                     // see R9
			if (hitMask)  maskQ       <= pwdata[1:0];
		end
	end

	// Read mux; status also shows the running line count
	assign rdMux = hitGain  ? 32'(gainQ) :
	               hitOff   ? 32'(offQ) :
	               hitClip  ? 32'(clipQ) :
	               hitLineA ? 32'(lineValQ[0]) :
	               hitLineB ? 32'(lineValQ[1]) :
	               hitSetup ? 32'(setupQ) :
	               hitBt    ? 32'(btQ) :
	               hitThr   ? 32'(thrQ) :
	               hitStat  ? {1'b0, lineCntQ, 14'h0000, statusQ} :
	               hitMask  ? 32'(maskQ) : 32'h0000_0000; // see R13

	// Answer registers; unmapped addresses read zero with pslverr
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			preadyQ  <= 1'b0;
			pslverrQ <= 1'b0;
			prdataQ  <= '0;
		end else begin
			preadyQ  <= apbAccess;
			pslverrQ <= apbAccess & ~addrHit;
			prdataQ  <= (apbAccess & ~pwrite) ? rdMux : 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Frame latching
	// ----------------------------------------------------------------
	logic [10:0] gainShQ;
	logic [9:0]  offShQ;
	logic [15:0] setupShQ;

	// Settings stay put mid-frame so one image never mixes two gains
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gainShQ  <= `RPGOC_GAIN_RST;
			offShQ   <= '0;
			setupShQ <= '0;
		end else if (vsyncRise) begin
			gainShQ  <= gainQ;  // see R4
			offShQ   <= offQ;   // see R4
			setupShQ <= setupQ; // see R4
		end
	end

	// ----------------------------------------------------------------
	// Line counter and frame interrupts
	// ----------------------------------------------------------------
	logic [14:0] lineCntD;
	logic [1:0]  firedQ;

	// Restarts at vertical sync, saturates at the field maximum
	assign lineCntD = vsyncRise ? 15'h0000 :
	                  (hsyncRise && lineCntQ != `RPGOC_LINE_MAX) ? lineCntQ + 15'h0001 : lineCntQ;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lineCntQ <= '0;
		end else begin
			lineCntQ <= lineCntD; // see R5, R6
		end
	end

	// One channel per frame interrupt, each armed again by vertical sync
	for (genvar c = 0; c < 2; c++) begin : gIrq
		assign evtVec[c] = (vsyncRise | hsyncRise) & (lineCntD == lineValQ[c]) & (vsyncRise | ~firedQ[c]); // see R12
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				firedQ[c] <= 1'b0;
			end else begin
				firedQ[c] <= vsyncRise ? evtVec[c] : (firedQ[c] | evtVec[c]); // see R12
			end
		end
	end

	// Sticky status; an event in the clearing cycle survives
	assign statusD = (statusQ & ~((wrEn & hitStat) ? pwdata[1:0] : 2'b00)) | evtVec; // see R5, R6

	logic irqQ;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			statusQ <= '0;
			irqQ    <= 1'b0;
		end else begin
			statusQ <= statusD;
			irqQ    <= |(statusD & maskQ);
		end
	end

	// ----------------------------------------------------------------
	// Pixel datapath
	// ----------------------------------------------------------------
	rpgoc_pix_t gcPix;
	logic       gcValid;
	rpgoc_pix_t capFilt;
	logic       capFiltValid;
	logic       alawSh;
	logic [2:0] sliceSh;

	assign alawSh  = setupShQ[`RPGOC_SETUP_ALAW];
	assign sliceSh = setupShQ[`RPGOC_SETUP_SLICE];

	// Clip ceiling is live; only gain and offset wait for the frame
	rpgoc_gain_clip uGainClip (
		.clk      (clk),
		.nrst     (nrst),
		.inPix    (pinSyncQ[13:0]),
		.inValid  (pinSyncQ[15]),
		.inBlue   (pinSyncQ[14]),
		.gain     (gainShQ),
		.offset   (offShQ),
		.clip     (clipQ),
		.outPix   (gcPix),
		.outValid (gcValid)
	);

	rpgoc_filter3 uPipeFilt (
		.clk       (clk),
		.nrst      (nrst),
		.inPix     (gcPix),
		.inValid   (gcValid),
		.mode      (rpgoc_fmode_t'(setupShQ[`RPGOC_SETUP_PIPE])),
		.threshold (thrQ),
		.outPix    (pipeData),
		.outValid  (pipeValid)
	);

	rpgoc_filter3 uCapFilt (
		.clk       (clk),
		.nrst      (nrst),
		.inPix     (gcPix),
		.inValid   (gcValid),
		.mode      (rpgoc_fmode_t'(setupShQ[`RPGOC_SETUP_CAP])),
		.threshold (thrQ),
		.outPix    (capFilt),
		.outValid  (capFiltValid)
	);

	// Capture and statistics outputs
	logic [13:0] capQ;
	logic        capValidQ;
	logic [9:0]  statsQ;
	logic        statsValidQ;
	logic [1:0]  btOutQ;
	logic        stripeQ;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			capQ        <= '0;
			capValidQ   <= 1'b0;
			statsQ      <= '0;
			statsValidQ <= 1'b0;
		end else begin
			if (capFiltValid) begin
				capQ <= alawSh ? {6'h00, alawOf(sliceOf(capFilt, sliceSh))} : capFilt; // see R10, R11
			end
			if (gcValid) begin
				statsQ <= sliceOf(gcPix, sliceSh); // see R10
			end
			capValidQ   <= capFiltValid;
			statsValidQ <= gcValid;
		end
	end

	// Mode bits for neighbouring logic
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			btOutQ  <= '0;
			stripeQ <= 1'b0;
		end else begin
			btOutQ  <= btQ;
			stripeQ <= setupShQ[`RPGOC_SETUP_STRIPE]; // see R4
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata                   = prdataQ;
	assign pready                   = preadyQ;
	assign pslverr                  = pslverrQ;
	assign capData                  = capQ;
	assign capValid                 = capValidQ;
	assign statsData                = statsQ;
	assign statsValid               = statsValidQ;
	assign irq                      = irqQ;
	assign bt656PortEnable          = btOutQ[`RPGOC_BT656_ON];
	assign syncCodeCorrectionEnable = btOutQ[`RPGOC_BT656_ECC];
	assign colourPatternStripe      = stripeQ;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [1:0] evtCntQ;

	// Pulses of channel A since the last vertical sync
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			evtCntQ <= '0;
		end else if (vsyncRise) begin
			evtCntQ <= {1'b0, evtVec[0]};
		end else if (evtVec[0] && evtCntQ != 2'h3) begin
			evtCntQ <= evtCntQ + 2'h1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	chk_shadow_hold: assert property (!vsyncRise |=> $stable(gainShQ) && $stable(setupShQ) && $stable(offShQ)) // see R4
		else $error("setting changed outside vertical sync");
	chk_shadow_load: assert property (vsyncRise |=> setupShQ == $past(setupQ) && gainShQ == $past(gainQ)) // see R4
		else $error("setting not latched at vertical sync");
	chk_line_a_irq: assert property (hsyncRise && !firedQ[0] && lineCntD == lineValQ[0] |=> statusQ[0]) // see R5
		else $error("first frame interrupt missed");
	chk_line_b_irq: assert property (hsyncRise && !firedQ[1] && lineCntD == lineValQ[1] |=> statusQ[1]) // see R6
		else $error("second frame interrupt missed");
	chk_once_frame: assert property (evtCntQ <= 2'h1) // see R12
		else $error("frame interrupt pulsed twice");
	chk_set_wins: assert property (evtVec[0] && wrEn && hitStat && pwdata[0] |=> statusQ[0]) // see R12
		else $error("event lost to clear");
	chk_irq_level: assert property (|(statusQ & maskQ) && !(wrEn && hitStat) |=> irqQ) // see R5
		else $error("unmasked status without interrupt");
	chk_reserved_zero: assert property (apbAccess && !pwrite && hitSetup
		|=> (prdataQ & ~{16'h0000, `RPGOC_SETUP_MASK}) == 32'h0000_0000) // see R13
		else $error("reserved bits read nonzero");
	chk_alaw_narrow: assert property (capFiltValid && alawSh |=> capQ[13:8] == 6'h00) // see R11
		else $error("a-law output too wide");
	chk_slice_low: assert property (gcValid && sliceSh == `RPGOC_SLICE_MAX |=> statsQ == $past(gcPix[9:0])) // see R10
		else $error("lowest slice wrong");
	chk_apb_answer: assert property (apbAccess |=> preadyQ ##1 !preadyQ)
		else $error("apb answer timing wrong");

	cov_irq_a: cover property (vsyncRise ##[1:200] evtVec[0]);
	cov_irq_out: cover property (irqQ);
	cov_alaw_cap: cover property (capValidQ && alawSh);
	cov_slverr: cover property (preadyQ && pslverrQ);
endmodule
`default_nettype wire

// file: verification/rpgoc_sensor_model.sv
// Sensor-side model: raw samples, line starts and vertical sync.
// Assumes the bench calls its tasks from the clk domain.
`timescale 1ns/10ps
`default_nettype none

module rpgoc_sensor_model (
	input  wire logic        clk,
	output logic             vSync,
	output logic             lineStart,
	output logic             pixValid,
	output logic             pixBlue,
	output logic [13:0]      pixData
);
	// Pins idle low before the first task call
	initial begin
		vSync = 1'b0;
		lineStart = 1'b0;
		pixValid = 1'b0;
		pixBlue = 1'b0;
		pixData = 14'h0;
	end
	// One sample; data held a cycle past the strobe, then inverted so no stale value lingers
	task px(input logic b, input logic [13:0] d);
		@(posedge clk) pixValid <= 1'b1;
		pixBlue <= b;
		pixData <= d;
		@(posedge clk) pixValid <= 1'b0;
		@(posedge clk) pixData <= ~d;
		repeat (4) @(posedge clk);
	endtask
	// Vertical sync pulse, wide enough for the two-flop synchroniser
	task frame();
		@(posedge clk) vSync <= 1'b1;
		repeat (4) @(posedge clk);
		vSync <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	// One line start
	task line();
		@(posedge clk) lineStart <= 1'b1;
		repeat (2) @(posedge clk);
		lineStart <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
endmodule

`default_nettype wire

// file: verification/rpgoc_top_tb.sv
// Self-checking bench for the pixel gain/offset/clip stage.
// Assumes the register map header and the sensor model.
`timescale 1ns/10ps
`default_nettype none
`include "rpgoc_cfg.svh"

module rpgoc_top_tb;
	logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, irq, e, vs, hs, pv, pb, bt0, bt1, cp;
	logic [13:0] pd, pipeD, capD;
	logic [9:0] statsD;
	logic [13:0] ex [5] = '{14'hc8, 14'h82, 14'h50, 14'hc8, 14'hc8};
	int failCount = 0, samplesChecked = 0, cyc = 0;
	always #10 clk = ~clk;
	rpgoc_top i_rpgoc_top (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.vertSyncPulse(vs), .lineStartPulse(hs), .pixValid(pv), .pixBlueMag(pb), .pixData(pd),
		.pipeData(pipeD), .pipeValid(), .capData(capD), .capValid(), .statsData(statsD),
		.statsValid(), .irq(irq), .bt656PortEnable(bt0), .syncCodeCorrectionEnable(bt1),
		.colourPatternStripe(cp));
	rpgoc_sensor_model i_rpgoc_sensor_model (.clk(clk), .vSync(vs), .lineStart(hs),
		.pixValid(pv), .pixBlue(pb), .pixData(pd));
	// ----------------------------------------------------------------
	// Bus and compare helpers
	// ----------------------------------------------------------------
	task chk(input logic [31:0] s, input logic [31:0] x);
		samplesChecked++;
		if (s !== x) begin
			failCount++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	// Request held until pready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r, x);
	endtask
	// Three samples and a repeat of the last, which pushes the window (c,m,a) to the output
	task px3(input logic b, input logic [13:0] a, input logic [13:0] m, input logic [13:0] c);
		i_rpgoc_sensor_model.px(b, a);
		i_rpgoc_sensor_model.px(b, m);
		i_rpgoc_sensor_model.px(b, c);
		i_rpgoc_sensor_model.px(b, c);
		repeat (4) @(posedge clk);
	endtask
	task finalReport();
		$display("checks=%0d mismatches=%0d", samplesChecked, failCount);
		if (failCount == 0 && samplesChecked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Hang guard, far above the thousand or so cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failCount++;
			finalReport();
		end
	end
	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		rd(`RPGOC_ADDR_GAIN, 32'h100);
		rd(`RPGOC_ADDR_CLIP, 32'h3fff);
		rd(8'h40, 32'h0);
		chk({31'h0, e}, 32'h1);
		apb(1'b1, `RPGOC_ADDR_BT656, 32'hffffffff);
		rd(`RPGOC_ADDR_BT656, 32'h3);
		chk({bt1, bt0}, 32'h3);
		apb(1'b1, `RPGOC_ADDR_OFFSET, 32'hffffffff);
		rd(`RPGOC_ADDR_OFFSET, 32'h3ff);
		apb(1'b1, `RPGOC_ADDR_OFFSET, 32'h5);
		apb(1'b1, `RPGOC_ADDR_GAIN, 32'h200);
		px3(1'b1, 14'h64, 14'h64, 14'h64);
		chk(pipeD, 32'h64);
		i_rpgoc_sensor_model.frame();
		px3(1'b1, 14'h64, 14'h64, 14'h64);
		chk(pipeD, 32'hcd);
		px3(1'b0, 14'h64, 14'h64, 14'h64);
		chk(pipeD, 32'h69);
		apb(1'b1, `RPGOC_ADDR_CLIP, 32'h12c);
		px3(1'b1, 14'h3e8, 14'h3e8, 14'h3e8);
		chk(pipeD, 32'h12c);
		apb(1'b1, `RPGOC_ADDR_CLIP, 32'h3fff);
		apb(1'b1, `RPGOC_ADDR_OFFSET, 32'h0);
		// Every filter code on both paths, last pass with a high median threshold
		for (int k = 0; k < 5; k++) begin
			apb(1'b1, `RPGOC_ADDR_MEDTHR, (k == 4) ? 32'hc8 : 32'h0);
			apb(1'b1, `RPGOC_ADDR_SETUP, (k == 4) ? 32'ha00 : 32'((k << 10) | (k << 8)));
			i_rpgoc_sensor_model.frame();
			px3(1'b0, 14'h28, 14'hc8, 14'h50);
			chk(pipeD, ex[k]);
			chk(capD, ex[k]);
		end
		// Every slice code; reserved codes fall back to the top slice
		for (int k = 0; k < 8; k++) begin
			apb(1'b1, `RPGOC_ADDR_SETUP, 32'(k << 2));
			i_rpgoc_sensor_model.frame();
			px3(1'b0, 14'h2a5b, 14'h2a5b, 14'h2a5b);
			chk(statsD, (32'h2a5b >> ((k > 4) ? 4 : 4 - k)) & 32'h3ff);
		end
		apb(1'b1, `RPGOC_ADDR_SETUP, 32'h11);
		i_rpgoc_sensor_model.frame();
		px3(1'b0, 14'h3ff, 14'h3ff, 14'h3ff);
		chk(capD, 32'hbf);
		apb(1'b1, `RPGOC_ADDR_LINEA, 32'h3);
		apb(1'b1, `RPGOC_ADDR_LINEB, 32'h5);
		apb(1'b1, `RPGOC_ADDR_MASK, 32'h2);
		apb(1'b1, `RPGOC_ADDR_STATUS, 32'h3);
		i_rpgoc_sensor_model.frame();
		repeat (3) i_rpgoc_sensor_model.line();
		rd(`RPGOC_ADDR_STATUS, 32'h30001);
		chk(irq, 32'h0);
		repeat (2) i_rpgoc_sensor_model.line();
		rd(`RPGOC_ADDR_STATUS, 32'h50003);
		chk(irq, 32'h1);
		apb(1'b1, `RPGOC_ADDR_STATUS, 32'h1);
		rd(`RPGOC_ADDR_STATUS, 32'h50002);
		apb(1'b1, `RPGOC_ADDR_STATUS, 32'h2);
		rd(`RPGOC_ADDR_STATUS, 32'h50000);
		chk(irq, 32'h0);
		repeat (2) i_rpgoc_sensor_model.line();
		rd(`RPGOC_ADDR_STATUS, 32'h70000);
		// Reserved setup bits, pattern latch, offset alone under zero gain
		apb(1'b1, `RPGOC_ADDR_SETUP, 32'hffffffff);
		rd(`RPGOC_ADDR_SETUP, 32'hf3d);
		chk(cp, 32'h0);
		apb(1'b1, `RPGOC_ADDR_GAIN, 32'h0);
		apb(1'b1, `RPGOC_ADDR_OFFSET, 32'h7b);
		i_rpgoc_sensor_model.frame();
		px3(1'b1, 14'h64, 14'h64, 14'h64);
		chk(cp, 32'h1);
		chk(pipeD, 32'h7b);
		chk(capD, 32'h7);
		finalReport();
	end
endmodule

`default_nettype wire
